// *** rtl/pxc_ext_regs.sv ***
// Extended control registers one and two of the transceiver management map.
// Assumes a frame engine on clk presents one word access per cycle at most, and that
// straps and remote-fault/energy pins arrive asynchronously from outside.
// Serial frame timing and the other management words are handled outside this block.
//
// Functional notes
// - Role bit zero means node; repeater unsupported.
// - Speed from basic control or hardware pin.
// - Bank select steers accesses; reset 00.
// - Pair tristate bit floats twisted pair lines.
// - Auto power-down of 100TX; resets to one.
// - Boost bit raises digital output drive strength.
`timescale 1ns/100ps
`default_nettype none

module pxc_ext_regs
   import pxc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire pxc_req_s    req,
   input  wire logic        req_valid,
   output logic [15:0]      rd_data,
   output logic             rd_hit,
   output logic             legacy_bank,
   output logic             node_mode,
   output logic             speed_100,
   input  wire logic        basic_speed_sel,
   input  wire logic        speed_pin,
   input  wire logic        strap_role,
   input  wire logic        strap_speed_src,
   input  wire logic        remote_fault_pin,
   input  wire logic        no_signal_pin,
   output logic             pair_tristate_enable,
   output logic             line_drive_en,
   output logic             auto_crossover_enable,
   output logic             crossover_manual_select,
   output logic             tx_power_down,
   output logic             drive_boost
);

   // Two-stage synchronisers for pins; stage one feeds stage two only.
   // The pins carry no reset, so their first two samples after power-up are unknown;
   // reset has to be held for at least three edges before the straps are trusted.
   logic [4:0] sync_a;                   // First stage
   logic [4:0] sync_b;                   // Second stage, the only one read
   logic [15:0] ext_one;                 // extended_control_one storage
   logic [15:0] ext_two;                 // extended_control_two storage
   logic [15:0] next_rd_data;            // Read mux result
   logic        next_rd_hit;             // Address served here

   // Decode of the access address under the current bank.
   // Register one stays reachable in every bank, or software could never switch back;
   // under the legacy bank the word at 0x14 belongs to the legacy set and is not served here.
   wire [1:0] bank_code = {ext_one[PXC_ONE_BANK_HI], ext_one[PXC_ONE_BANK_LO]};
   wire       bank_legacy = (bank_code == PXC_BANK_LEGACY);
   wire       hit_one = (req.addr == PXC_ADDR_EXT_ONE);
   wire       hit_two = (req.addr == PXC_ADDR_EXT_TWO) && !bank_legacy;
   wire       wr_one = req_valid && req.wr && hit_one;
   wire       wr_two = req_valid && req.wr && hit_two;

   // Synchronised pin views
   // Speed, fault and no-signal are read live; role and speed source only under reset
   wire s_speed  = sync_b[0];
   wire s_role   = sync_b[1];
   wire s_src    = sync_b[2];
   wire s_fault  = sync_b[3];
   wire s_nosig  = sync_b[4];

   // Merge a write into a register, keeping protected bits
   // Used for both registers so the masking rule lives in one place
   function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
                                         input logic [15:0] mask);
      merge = (old & ~mask) | (wd & mask);
   endfunction : merge

   // Pin synchronisers; async pins must settle before any logic sees them
   always_ff @(posedge clk)
   begin
      sync_a <= {no_signal_pin, remote_fault_pin, strap_speed_src, strap_role, speed_pin};
      sync_b <= sync_a;
   end

   // Register one: straps latched during reset, live fault bit refreshed every cycle out of reset
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         // Straps are sampled on every reset edge, so the last one before release counts
         ext_one <= PXC_ONE_RESET;
         ext_one[PXC_ONE_ROLE] <= s_role;
         ext_one[PXC_ONE_SPEED_SRC] <= s_src;
      end
      else
      begin
         // Writes cannot touch the remote fault bit or reserved bit 10
         if (wr_one)
            ext_one <= merge(ext_one, req.data, PXC_ONE_WMASK);
         // The later assignment wins, so the live fault view overrides a write in the same cycle
         ext_one[PXC_ONE_RFAULT] <= s_fault;
      end
   end

   // Register two: plain read/write
   // Reserved bits are kept writable; software is expected to write back their defaults
   always_ff @(posedge clk)
   begin
      if (!reset_n)
         ext_two <= PXC_TWO_RESET;
      else if (wr_two)
         ext_two <= merge(ext_two, req.data, PXC_TWO_WMASK);
   end

   // Read mux; unserved addresses answer zero with rd_hit low
   // A write never answers, so rd_hit means a served read and nothing else
   always_comb
   begin
      next_rd_data = 16'h0000;
      next_rd_hit  = 1'b0;
      if (req_valid && !req.wr && hit_one)
      begin
         next_rd_data = ext_one;
         next_rd_hit  = 1'b1;
      end
      else if (req_valid && !req.wr && hit_two)
      begin
         next_rd_data = ext_two;
         next_rd_hit  = 1'b1;
      end
   end

   // Read data registered one cycle after the request
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         rd_data <= 16'h0000;
         rd_hit  <= 1'b0;
      end
      else
      begin
         rd_data <= next_rd_data;
         rd_hit  <= next_rd_hit;
      end
   end

   // Control outputs; repeater is unsupported, so the device stays a node regardless.
   // The role bit is still stored and read back so software sees what it wrote.
   // Power-down needs both the enable bit and an absent signal, never the bit alone.
   assign node_mode               = 1'b1;
   assign legacy_bank             = bank_legacy;
   assign speed_100               = ext_one[PXC_ONE_SPEED_SRC] ? s_speed : basic_speed_sel;
   assign pair_tristate_enable    = ext_one[PXC_ONE_PAIR_TRI];
   assign line_drive_en           = !ext_one[PXC_ONE_PAIR_TRI];
   assign auto_crossover_enable   = ext_one[PXC_ONE_XOVER_EN];
   assign crossover_manual_select = ext_one[PXC_ONE_XOVER_SEL];
   assign tx_power_down           = ext_one[PXC_ONE_AUTO_PD] && s_nosig;
   assign drive_boost             = ext_two[PXC_TWO_BOOST];

   // Checks, all on clk and quiet while reset is held.
   // The strap and reset-value checks key on the release edge, the only cycle in
   // which the reset contents are seen before software can touch them.
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   // Node role and speed selection
   a_node_always: assert property (node_mode == 1'b1)
      else $error("node mode dropped");
   a_speed_source: assert property (speed_100 == (ext_one[PXC_ONE_SPEED_SRC] ? s_speed : basic_speed_sel))
      else $error("speed source wrong");
   // Bank steering
   a_bank_block: assert property (bank_legacy && req_valid && !req.wr && req.addr == PXC_ADDR_EXT_TWO
      |=> !rd_hit)
      else $error("legacy bank served reg two");
   a_bank_reset: assert property ($rose(reset_n) |-> bank_code == 2'b00)
      else $error("bank not reset to 00");
   // Field effects and write behaviour
   a_pair_float: assert property (wr_one && req.data[PXC_ONE_PAIR_TRI] |=> !line_drive_en)
      else $error("lines still driven");
   a_auto_pd: assert property ($rose(reset_n) |-> ext_one[PXC_ONE_AUTO_PD])
      else $error("auto power-down not one at reset");
   a_boost_write: assert property (wr_two |=> drive_boost == $past(req.data[PXC_TWO_BOOST]))
      else $error("boost not written");
   a_fault_ro: assert property (wr_one |=> ext_one[PXC_ONE_RFAULT] == $past(s_fault))
      else $error("remote fault writable");
   // Read path
   a_read_one: assert property (req_valid && !req.wr && hit_one |=> rd_hit && rd_data == $past(ext_one))
      else $error("reg one read wrong");

   // A refused write to register two must leave it untouched
   a_two_refused: assert property (bank_legacy && req_valid && req.wr && req.addr == PXC_ADDR_EXT_TWO
      |=> ext_two == $past(ext_two))
      else $error("legacy bank wrote reg two");
   // Read data is zero whenever no answer stands, so stale words cannot leak
   a_read_quiet: assert property (!rd_hit |-> rd_data == 16'h0000)
      else $error("read data without hit");
   // Line drive and the tristate request are always opposite
   a_tri_inverse: assert property (line_drive_en == !pair_tristate_enable)
      else $error("line drive not inverse of tristate");
   // No power-down while the automatic enable bit is clear
   a_pd_gated: assert property (!ext_one[PXC_ONE_AUTO_PD] |-> !tx_power_down)
      else $error("power-down without enable");
   // Normal drive strength comes out of every reset
   a_boost_reset: assert property ($rose(reset_n) |-> !drive_boost)
      else $error("boost set after reset");
   // Straps seen on the last reset edge are what the register holds at release
   a_src_strap: assert property ($rose(reset_n) |-> ext_one[PXC_ONE_SPEED_SRC] == $past(s_src))
      else $error("speed source strap lost");
   a_role_strap: assert property ($rose(reset_n) |-> ext_one[PXC_ONE_ROLE] == $past(s_role))
      else $error("role strap lost");

   // Main scenarios: bank switch, refused access, pin speed, power-down, tristate
   c_legacy: cover property (wr_one && req.data[PXC_ONE_BANK_HI:PXC_ONE_BANK_LO] == PXC_BANK_LEGACY);
   c_refused: cover property (bank_legacy && req_valid && req.addr == PXC_ADDR_EXT_TWO);
   c_hw_speed: cover property (ext_one[PXC_ONE_SPEED_SRC] && speed_100);
   c_power_down: cover property (tx_power_down);
   c_tristate: cover property (pair_tristate_enable);

endmodule : pxc_ext_regs

`default_nettype wire

// *** rtl/pxc_pkg.sv ***
// Constants, field layout and carrier types for the extended control register pair.
// Assumes a management frame engine elsewhere turns serial frames into word accesses.
package pxc_pkg;

   // Register addresses on the management address space
   localparam logic [4:0] PXC_ADDR_EXT_ONE = 5'h13;
   localparam logic [4:0] PXC_ADDR_EXT_TWO = 5'h14;

   // Field positions in extended_control_one
   localparam int PXC_ONE_ROLE      = 15;
   localparam int PXC_ONE_SPEED_SRC = 14;
   localparam int PXC_ONE_RFAULT    = 13;
   localparam int PXC_ONE_BANK_HI   = 12;
   localparam int PXC_ONE_BANK_LO   = 11;
   localparam int PXC_ONE_XOVER_EN  = 9;
   localparam int PXC_ONE_XOVER_SEL = 8;
   localparam int PXC_ONE_PAIR_TRI  = 7;
   localparam int PXC_ONE_AUTO_PD   = 0;

   // Field positions in extended_control_two
   localparam int PXC_TWO_BOOST = 15;

   // Reset values; strap and live bits are merged in separately
   localparam logic [15:0] PXC_ONE_RESET = 16'h0201;
   localparam logic [15:0] PXC_TWO_RESET = 16'h3FE9;

   // Bits software may change; remote fault and reserved bit 10 are read-only
   localparam logic [15:0] PXC_ONE_WMASK = 16'hDBFF;
   localparam logic [15:0] PXC_TWO_WMASK = 16'hFFFF;

   // Bank selector codes
   localparam logic [1:0] PXC_BANK_LEGACY = 2'b01;

   // Word access request from the management frame engine
   typedef struct packed {
      logic [4:0]  addr;
      logic        wr;
      logic [15:0] data;
   } pxc_req_s;

endpackage : pxc_pkg

// *** sim/pxc_sta_model.sv ***
// Station management model that issues word accesses to the register pair.
// Assumes the bench calls access() from its own sequence, on the rising edges of clk.
`timescale 1ns/100ps
`default_nettype none

module pxc_sta_model
   import pxc_pkg::*;
(
   input  wire logic clk,
   output pxc_req_s  req,
   output logic      req_valid
);
   // Idle until the first access
   initial
   begin
      req_valid = 1'b0;
      req       = '0;
   end

   // One access: launched just after an edge and held through the edge that takes it
   task automatic access(input logic [4:0] a, input logic w, input logic [15:0] d);
      @(posedge clk);
      #1;
      req.addr  = a;
      req.wr    = w;
      req.data  = d;  // Caller's data is driven as given, reserved bits included
      req_valid = 1'b1;
      @(posedge clk);
      #1;
      req_valid = 1'b0;
      // Released data is flipped, so a stale word can never pass for a fresh one
      req.data  = ~d;
   endtask : access
endmodule : pxc_sta_model

`default_nettype wire

// *** sim/pxc_ext_regs_test.sv ***
// Self-checking bench for the extended control register pair.
// Assumes the management model drives accesses; read results are queued and matched.
`timescale 1ns/100ps
`default_nettype none

module pxc_ext_regs_test
   import pxc_pkg::*;
();
   logic clk = 0, reset_n = 0, basic_speed_sel = 0, speed_pin = 0;
   logic strap_role = 0, strap_speed_src = 0, remote_fault_pin = 1, no_signal_pin = 1;
   pxc_req_s req;
   logic req_valid, rd_hit, legacy_bank, node_mode, speed_100, pair_tristate_enable;
   logic line_drive_en, auto_crossover_enable, crossover_manual_select, tx_power_down, drive_boost;
   logic [15:0] rd_data, d, two_val, exp_q[$];
   int bad_count = 0, n_compared = 0;

   always #5 clk = ~clk;

   pxc_ext_regs i_dut(.clk, .reset_n, .req, .req_valid, .rd_data, .rd_hit, .legacy_bank, .node_mode,
      .speed_100, .basic_speed_sel, .speed_pin, .strap_role, .strap_speed_src, .remote_fault_pin,
      .no_signal_pin, .pair_tristate_enable, .line_drive_en, .auto_crossover_enable,
      .crossover_manual_select, .tx_power_down, .drive_boost);
   pxc_sta_model i_sta(.clk, .req, .req_valid);

   // Value compare, counted
   task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e)
      begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, e, g);
      end
   endtask : chk

   // Read request; a refused read queues nothing, so a stray answer shows as a mismatch
   task automatic rd(input logic [4:0] a, input logic [15:0] e, input logic hit);
      if (hit)
         exp_q.push_back(e);
      i_sta.access(a, 1'b0, 16'h0000);
      @(posedge clk);
      #1;
   endtask : rd

   // Verdict
   task automatic close_out();
      if (exp_q.size() != 0)
         bad_count++;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : close_out

   // Read watcher: each answer takes the oldest note
   always @(posedge clk)
   begin
      if (rd_hit === 1'b1)
         chk("read data", (exp_q.size() > 0) ? exp_q.pop_front() : ~rd_data, rd_data);
   end

   // Hang guard
   initial
   begin
      repeat (5000) @(posedge clk);
      bad_count++;
      close_out();
   end

   initial
   begin
      void'($urandom(47709));
      two_val = 16'h3FE9;
      repeat (12) @(posedge clk);
      #1 reset_n = 1'b1;
      chk("node", 16'h0001, node_mode);
      chk("boost", 16'h0000, drive_boost);
      chk("tristate", 16'h0000, pair_tristate_enable);
      chk("power down", 16'h0001, tx_power_down);
      basic_speed_sel = 1'b1;
      #1 chk("speed", 16'h0001, speed_100);
      rd(PXC_ADDR_EXT_ONE, 16'h2201, 1'b1);
      rd(PXC_ADDR_EXT_TWO, 16'h3FE9, 1'b1);
      rd(5'h05, 16'h0000, 1'b0);
      remote_fault_pin = 1'b0;
      for (int b = 0; b < 4; b++)
      begin
         d = 16'($urandom());
         no_signal_pin = d[10];
         i_sta.access(PXC_ADDR_EXT_TWO, 1'b1, d);
         // Pass 2 writes while the legacy bank chosen in pass 1 is set, so that write is refused
         if (b != 2)
            two_val = d;
         d = {2'b00, 1'b1, 2'(b), 1'b0, d[9:7], 6'h00, d[0]};
         i_sta.access(PXC_ADDR_EXT_ONE, 1'b1, d);
         chk("legacy bank", 16'(b == 1), legacy_bank);
         chk("boost", 16'(two_val[15]), drive_boost);
         chk("tristate", 16'(d[7]), pair_tristate_enable);
         chk("line drive", 16'(!d[7]), line_drive_en);
         chk("crossover", 16'(d[9:8]), {auto_crossover_enable, crossover_manual_select});
         rd(PXC_ADDR_EXT_ONE, d & 16'hDBFF, 1'b1);
         rd(PXC_ADDR_EXT_TWO, two_val, b != 1);
         chk("power down", 16'(d[0] & no_signal_pin), tx_power_down);
      end
      reset_n = 1'b0;
      strap_speed_src = 1'b1;
      repeat (4) @(posedge clk);
      #1 reset_n = 1'b1;
      basic_speed_sel = 1'b0;
      speed_pin = 1'b1;
      rd(PXC_ADDR_EXT_ONE, 16'h4201, 1'b1);
      chk("speed pin", 16'h0001, speed_100);
      chk("legacy bank", 16'h0000, legacy_bank);
      close_out();
   end
endmodule : pxc_ext_regs_test

`default_nettype wire
